// file: shared/fault_status_defs.vh
// constants for the device and bus fault status registers
// assumes ref_clk at 200 MHz and a 16-bit lsb-first serial frame
//
// What this block does
// - restart cause: 00 cleared, 01 failure or fail-safe wake, 10 sleep wake
// - sleep wake gives 10; watchdog, thermal, main low, gated high give 01
// - bit 5 latches reset output stuck high
// - bit 4 latches fail-safe input pattern error
// - watchdog fail counter 01 then 10; fail outputs per config
// - watchdog fail counter clears on good trigger, only self-clearing bits
// - invalid serial command sets bit 1 and is not executed
// - invalid command flag cleared only by serial clear, soft reset or power-on
// - bit 0 shows fail outputs were activated, until cleared
// - lin fault code: 01 thermal, 10 tx dominant, 11 bus dominant
// - can fault code: 01 thermal, 10 tx dominant, 11 bus dominant
// - can supply low sets bus bit 0 and disables can transmitter
// - tx dominant timeout recovers on tx high, wake-capable or off
// - bus dominant timeout recovers on recessive bus, wake-capable or off
// - supply low recovers once supply is above threshold again
// - after any fault tx input must stay high enable time first
// - can supply comparator live in normal, rx-only, or woken wake mode
// - bus status bits 7, 4, 3 always read zero
// - power-on and soft reset clear both registers
// - restart entry keeps device status unchanged
// - restart entry zeroes bus bits 7, 4, 3, keeps others
// - access bit 0 reads a status byte unchanged
// - access bit 1 clears the addressed byte except the watchdog fail counter
// - flags other than the counter stay set until serial clear
`ifndef FAULT_STATUS_DEFS_VH
`define FAULT_STATUS_DEFS_VH

// ----------------------------------------
// addresses and frame
// ----------------------------------------
`define DEV_INFO_ADDR   7'h43
`define BUS_COMM_ADDR   7'h44
`define FRAME_BITS      5'h10
`define ADDR_BITS       5'h08

// ----------------------------------------
// fields
// ----------------------------------------
`define CAUSE_HI        7
`define CAUSE_LO        6
`define STUCK_BIT       5
`define FSI_ERR_BIT     4
`define WDC_HI          3
`define WDC_LO          2
`define BADCMD_BIT      1
`define FO_BIT          0
`define LIN_HI          6
`define LIN_LO          5
`define CAN_HI          2
`define CAN_LO          1
`define CAN_UV_BIT      0
`define BUS_LIVE_MASK   8'h67
`define REG_RESET       8'h00

// ----------------------------------------
// codes
// ----------------------------------------
`define CAUSE_NONE      2'h0
`define CAUSE_FAIL      2'h1
`define CAUSE_SLEEP     2'h2
`define WDC_ONE         2'h1
`define WDC_TWO         2'h2
`define FLT_NONE        2'h0
`define FLT_TSD         2'h1
`define FLT_TXD         2'h2
`define FLT_BUS         2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ         200
`define TXEN_TIME_NS    2000
`define TXEN_CYCLES     ((`TXEN_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

// file: design/xcvr_guard.v
// transmitter guard for one transceiver: fault hold and recovery
// assumes all inputs on ref_clk; tx_high already synchronised
`timescale 1ns/100ps
`include "fault_status_defs.vh"
`default_nettype none
module xcvr_guard #(
    parameter integer TXEN_CYC = `TXEN_CYCLES
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // fault events and levels
    input  wire       tsd_evt,
    input  wire       txd_evt,
    input  wire       bus_evt,
    input  wire       supply_low,
    input  wire       tsd_active,
    // recovery conditions
    input  wire       tx_high,
    input  wire       bus_recessive,
    input  wire       off_or_wake,
    // transmitter enable
    output reg        tx_en_q
);
    localparam [2:0] RUN   = 3'b001;
    localparam [2:0] FAULT = 3'b010;
    localparam [2:0] WAIT  = 3'b100;

    reg [2:0]  state_q;
    reg [1:0]  kind_q;
    reg [15:0] cnt_q;
    reg        clear_now;

    // ----------------------------------------
    // recovery test
    // ----------------------------------------
    always @* begin
        case (kind_q)
            `FLT_TXD: clear_now = tx_high | off_or_wake;
            `FLT_BUS: clear_now = bus_recessive | off_or_wake;
            `FLT_TSD: clear_now = ~tsd_active;
            default:  clear_now = ~supply_low;
        endcase
    end

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= RUN;
            kind_q  <= `FLT_NONE;
            cnt_q   <= 16'h0000;
            tx_en_q <= 1'b1;
        end else if (tsd_evt | txd_evt | bus_evt | supply_low) begin
            // new fault overrides any recovery in progress
            state_q <= FAULT;
            kind_q  <= bus_evt ? `FLT_BUS : txd_evt ? `FLT_TXD :
                       tsd_evt ? `FLT_TSD :
                       (state_q == RUN ? `FLT_NONE : kind_q);
            tx_en_q <= 1'b0;
        end else begin
            case (state_q)
                RUN: begin
                    tx_en_q <= 1'b1;
                end
                FAULT: begin
                    cnt_q <= 16'h0000;
                    if (clear_now) begin
                        state_q <= WAIT;
                    end
                end
                WAIT: begin
                    if (!tx_high) begin
                        cnt_q <= 16'h0000;
                    end else if (cnt_q >= TXEN_CYC[15:0] - 16'h0001) begin
                        state_q <= RUN;
                        tx_en_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                default: begin
                    state_q <= RUN;
                end
            endcase
        end
    end
endmodule // xcvr_guard
`default_nettype wire

// file: design/device_bus_fault_status.v
// device and bus fault status registers behind the serial control port
// assumes serial pins are asynchronous; event inputs are on ref_clk
`timescale 1ns/100ps
`include "fault_status_defs.vh"
`default_nettype none
module device_bus_fault_status #(
    parameter integer TXEN_CYC = `TXEN_CYCLES
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       reset_n,
    input  wire       soft_reset,
    input  wire       restart_entry,
    // serial control port
    input  wire       ser_clk,
    input  wire       ser_sel_n,
    input  wire       ser_in,
    output reg        ser_out_q,
    output reg        ser_out_en_q,
    // restart causes
    input  wire       sleep_wake_evt,
    input  wire       failsafe_wake_evt,
    input  wire       thermal_shutdown_level2,
    input  wire       main_supply_low,
    input  wire       main_supply_high,
    input  wire       main_overvolt_restart_en,
    // watchdog and fail-safe
    input  wire       reset_out_stuck_high,
    input  wire       failsafe_input_error,
    input  wire       watchdog_fail_count_evt,
    input  wire       wd_trigger_ok,
    input  wire       fail_config_one,
    input  wire       fail_outputs_release,
    output reg        fail_output_pins_q,
    // lin transceiver
    input  wire       lin_tsd_evt,
    input  wire       lin_tx_stuck_dominant,
    input  wire       lin_line_stuck_dominant,
    input  wire       lin_supply_low,
    input  wire       lin_bus_recessive,
    input  wire       lin_off_or_wake,
    input  wire       lin_transmit_input,
    output wire       lin_tx_enable,
    // can transceiver
    input  wire       thermal_shutdown_level1,
    input  wire       can_tsd_evt,
    input  wire       can_tx_stuck_dominant,
    input  wire       can_line_stuck_dominant,
    input  wire       can_supply_below,
    input  wire       can_normal_mode,
    input  wire       can_rx_only_mode,
    input  wire       can_wake_mode,
    input  wire       wake_pattern_seen,
    input  wire       can_bus_recessive,
    input  wire       can_off_or_wake,
    input  wire       can_transmit_input,
    output wire       can_tx_enable,
    // register images
    output reg  [7:0] device_info_status_q,
    output reg  [7:0] bus_comm_status_one_q
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg [1:0] rst_sync_q;
    wire      rst_n;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // stage one feeds stage two only
    reg [4:0] pin_s1_q;
    reg [4:0] pin_s2_q;
    reg       sclk_prev_q;
    reg       sel_prev_q;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q    <= 5'h1a;
            pin_s2_q    <= 5'h1a;
            sclk_prev_q <= 1'b0;
            sel_prev_q  <= 1'b1;
        end else begin
            pin_s1_q    <= {can_transmit_input, lin_transmit_input,
                            ser_in, ser_sel_n, ser_clk};
            pin_s2_q    <= pin_s1_q;
            sclk_prev_q <= pin_s2_q[0];
            sel_prev_q  <= pin_s2_q[1];
        end
    end

    wire sclk_s  = pin_s2_q[0];
    wire sel_n_s = pin_s2_q[1];
    wire sdi_s   = pin_s2_q[2];
    wire lin_txd = pin_s2_q[3];
    wire can_txd = pin_s2_q[4];
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire sclk_fall = ~sclk_s & sclk_prev_q;
    wire sel_fall  = ~sel_n_s & sel_prev_q;
    wire sel_rise  = sel_n_s & ~sel_prev_q;

    // ----------------------------------------
    // serial frame
    // ----------------------------------------
    reg [15:0] sh_q;
    reg [4:0]  bits_q;
    reg [7:0]  tx_q;
    reg        over_q;
    wire [7:0] rd_val = rd_byte(sh_q[14:8]);

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q         <= 16'h0000;
            bits_q       <= 5'h00;
            tx_q         <= 8'h00;
            over_q       <= 1'b0;
            ser_out_q    <= 1'b0;
            ser_out_en_q <= 1'b0;
        end else begin
            ser_out_en_q <= ~sel_n_s;
            if (sel_fall) begin
                bits_q    <= 5'h00;
                over_q    <= 1'b0;
                ser_out_q <= 1'b0;
            end else if (!sel_n_s && sclk_rise) begin
                // lsb first, first bit ends in sh_q[0]
                sh_q <= {sdi_s, sh_q[15:1]};
                if (bits_q == `FRAME_BITS) begin
                    over_q <= 1'b1;
                end else begin
                    bits_q <= bits_q + 5'h01;
                end
            end else if (!sel_n_s && sclk_fall) begin
                if (bits_q == `ADDR_BITS) begin
                    // read returns the byte as held
                    ser_out_q <= rd_val[0];
                    tx_q      <= {1'b0, rd_val[7:1]};
                end else if (bits_q > `ADDR_BITS) begin
                    ser_out_q <= tx_q[0];
                    tx_q      <= {1'b0, tx_q[7:1]};
                end else begin
                    ser_out_q <= 1'b0;
                end
            end
        end
    end

    function [7:0] rd_byte;
        input [6:0] addr;
        begin
            if (addr == `DEV_INFO_ADDR) begin
                rd_byte = device_info_status_q;
            end else if (addr == `BUS_COMM_ADDR) begin
                rd_byte = bus_comm_status_one_q;
            end else begin
                rd_byte = 8'h00;
            end
        end
    endfunction

    wire frame_end = sel_rise;
    wire frame_ok  = (bits_q == `FRAME_BITS) && !over_q;
    wire bad_cmd   = frame_end && !frame_ok;
    // access bit set clears the byte except the device watchdog counter
    wire clr_cmd   = frame_end && frame_ok && sh_q[7];
    wire clr_dev   = clr_cmd && (sh_q[6:0] == `DEV_INFO_ADDR);
    wire clr_bus   = clr_cmd && (sh_q[6:0] == `BUS_COMM_ADDR);

    // ----------------------------------------
    // event decode
    // ----------------------------------------
    // failure causes, high gated by enable
    wire fail_cause = watchdog_fail_count_evt | thermal_shutdown_level2 |
                      main_supply_low | failsafe_wake_evt |
                      (main_supply_high & main_overvolt_restart_en);
    wire can_cmp_en = can_normal_mode | can_rx_only_mode |
                      (can_wake_mode & wake_pattern_seen);
    wire can_uv     = can_cmp_en & can_supply_below;

    wire [1:0] wdc     = device_info_status_q[`WDC_HI:`WDC_LO];
    wire [1:0] wdc_inc = (wdc == `WDC_TWO) ? wdc : wdc + 2'h1;
    wire fo_fire = watchdog_fail_count_evt &&
                   (fail_config_one ? (wdc_inc == `WDC_ONE)
                                    : (wdc_inc == `WDC_TWO));

    function [1:0] flt_code;
        input tsd;
        input txd;
        input bus;
        input [1:0] old;
        begin
            if (bus) begin
                flt_code = `FLT_BUS;
            end else if (txd) begin
                flt_code = `FLT_TXD;
            end else if (tsd) begin
                flt_code = `FLT_TSD;
            end else begin
                flt_code = old;
            end
        end
    endfunction

    // ----------------------------------------
    // device status register
    // ----------------------------------------
    reg [7:0] dev_d;

    always @* begin
        dev_d = device_info_status_q;
        if (clr_dev) begin
            dev_d = `REG_RESET;
            dev_d[`WDC_HI:`WDC_LO] = wdc;
        end
        if (fail_cause) begin
            dev_d[`CAUSE_HI:`CAUSE_LO] = `CAUSE_FAIL;
        end else if (sleep_wake_evt) begin
            dev_d[`CAUSE_HI:`CAUSE_LO] = `CAUSE_SLEEP;
        end
        if (reset_out_stuck_high) begin
            dev_d[`STUCK_BIT] = 1'b1;
        end
        if (failsafe_input_error) begin
            dev_d[`FSI_ERR_BIT] = 1'b1;
        end
        if (watchdog_fail_count_evt) begin
            dev_d[`WDC_HI:`WDC_LO] = wdc_inc;
        end else if (wd_trigger_ok) begin
            dev_d[`WDC_HI:`WDC_LO] = `CAUSE_NONE;
        end
        if (bad_cmd) begin
            dev_d[`BADCMD_BIT] = 1'b1;
        end
        if (fo_fire) begin
            dev_d[`FO_BIT] = 1'b1;
        end
    end

    // ----------------------------------------
    // bus status register
    // ----------------------------------------
    reg [7:0] bus_d;

    always @* begin
        bus_d = bus_comm_status_one_q;
        if (clr_bus) begin
            bus_d = `REG_RESET;
        end
        bus_d[`LIN_HI:`LIN_LO] = flt_code(lin_tsd_evt,
            lin_tx_stuck_dominant, lin_line_stuck_dominant,
            bus_d[`LIN_HI:`LIN_LO]);
        bus_d[`CAN_HI:`CAN_LO] = flt_code(can_tsd_evt,
            can_tx_stuck_dominant, can_line_stuck_dominant,
            bus_d[`CAN_HI:`CAN_LO]);
        if (can_uv) begin
            bus_d[`CAN_UV_BIT] = 1'b1;
        end
        bus_d = bus_d & `BUS_LIVE_MASK;
    end

    // ----------------------------------------
    // register update
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            device_info_status_q  <= `REG_RESET;
            bus_comm_status_one_q <= `REG_RESET;
            fail_output_pins_q    <= 1'b0;
        end else if (soft_reset) begin
            device_info_status_q  <= `REG_RESET;
            bus_comm_status_one_q <= `REG_RESET;
            fail_output_pins_q    <= 1'b0;
        end else begin
            // restart entry has no effect here
            device_info_status_q  <= dev_d;
            bus_comm_status_one_q <= bus_d;
            if (fo_fire) begin
                fail_output_pins_q <= 1'b1;
            end else if (fail_outputs_release) begin
                fail_output_pins_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // transmitter guards
    // ----------------------------------------
    xcvr_guard #(
        .TXEN_CYC      (TXEN_CYC)
    ) u_lin_guard (
        .clk           (ref_clk),
        .rst_n         (rst_n),
        .tsd_evt       (lin_tsd_evt),
        .txd_evt       (lin_tx_stuck_dominant),
        .bus_evt       (lin_line_stuck_dominant),
        .supply_low    (lin_supply_low),
        .tsd_active    (thermal_shutdown_level1),
        .tx_high       (lin_txd),
        .bus_recessive (lin_bus_recessive),
        .off_or_wake   (lin_off_or_wake),
        .tx_en_q       (lin_tx_enable)
    );

    // can supply low holds transmitter off
    xcvr_guard #(
        .TXEN_CYC      (TXEN_CYC)
    ) u_can_guard (
        .clk           (ref_clk),
        .rst_n         (rst_n),
        .tsd_evt       (can_tsd_evt),
        .txd_evt       (can_tx_stuck_dominant),
        .bus_evt       (can_line_stuck_dominant),
        .supply_low    (can_uv),
        .tsd_active    (thermal_shutdown_level1),
        .tx_high       (can_txd),
        .bus_recessive (can_bus_recessive),
        .off_or_wake   (can_off_or_wake),
        .tx_en_q       (can_tx_enable)
    );

    // restart_entry needs no action: bus reserved bits are always low
    wire unused_ok = restart_entry;
endmodule // device_bus_fault_status
`default_nettype wire

// file: test/fault_status_monitor.sv
// checker for the fault status register bank
// assumes binding to the top module, all checks on ref_clk
`timescale 1ns/100ps
`default_nettype none
module fault_status_monitor (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic       soft_reset,
    input wire logic       ser_sel_n,
    // events
    input wire logic       reset_out_stuck_high,
    input wire logic       failsafe_input_error,
    input wire logic       wd_trigger_ok,
    input wire logic       watchdog_fail_count_evt,
    input wire logic       lin_line_stuck_dominant,
    input wire logic       can_line_stuck_dominant,
    input wire logic       can_supply_below,
    input wire logic       can_normal_mode,
    // outputs
    input wire logic       fail_output_pins_q,
    input wire logic       can_tx_enable,
    input wire logic [7:0] device_info_status_q,
    input wire logic [7:0] bus_comm_status_one_q
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [4:0] since_q;
    // cycles since the select line went high, saturating
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            since_q <= 5'h1f;
        else if (!ser_sel_n)
            since_q <= 5'h00;
        else if (since_q != 5'h1f)
            since_q <= since_q + 5'h01;
    end
    sequence frame_end;
        since_q < 5'h14;
    endsequence
    sequence soft_seen;
        $past(soft_reset);
    endsequence
    AST_STUCK_SET: assert property (reset_out_stuck_high
        |=> device_info_status_q[5]) else $error("stuck flag not set");
    AST_FSI_SET: assert property (failsafe_input_error
        |=> device_info_status_q[4]) else $error("fsi flag not set");
    AST_WDC_MAX: assert property (device_info_status_q[3:2] != 2'h3)
        else $error("watchdog count reached 3");
    AST_WDC_CLR: assert property (wd_trigger_ok && !watchdog_fail_count_evt
        |=> device_info_status_q[3:2] == 2'h0) else $error("count kept");
    AST_BAD_KEEP: assert property ($fell(device_info_status_q[1])
        |-> frame_end or soft_seen) else $error("bad cmd flag lost");
    AST_FO_SHOW: assert property ($rose(fail_output_pins_q)
        |-> ##[0:1] device_info_status_q[0]) else $error("fo bit missing");
    AST_LIN_BUS: assert property (lin_line_stuck_dominant
        |=> bus_comm_status_one_q[6:5] == 2'h3) else $error("lin code");
    AST_CAN_BUS: assert property (can_line_stuck_dominant
        |=> bus_comm_status_one_q[2:1] == 2'h3) else $error("can code");
    AST_CAN_UV: assert property (can_supply_below && can_normal_mode
        |=> bus_comm_status_one_q[0] ##[0:1] !can_tx_enable)
        else $error("can supply low not handled");
    AST_RSV_ZERO: assert property ((bus_comm_status_one_q & 8'h98) == 0)
        else $error("reserved bus bit set");
    AST_SOFT_CLR: assert property (soft_reset |=>
        device_info_status_q == 0 && bus_comm_status_one_q == 0)
        else $error("soft reset left bits");
endmodule // fault_status_monitor
bind device_bus_fault_status fault_status_monitor u_fault_status_monitor (
    .ref_clk, .reset_n, .soft_reset, .ser_sel_n, .reset_out_stuck_high,
    .failsafe_input_error, .wd_trigger_ok, .watchdog_fail_count_evt,
    .lin_line_stuck_dominant, .can_line_stuck_dominant, .can_supply_below,
    .can_normal_mode, .fail_output_pins_q, .can_tx_enable,
    .device_info_status_q, .bus_comm_status_one_q);
`default_nettype wire

// file: test/ser_master.sv
// serial control master standing in for the microcontroller
// assumes 16-bit lsb-first frames; clock idles low outside frames
`timescale 1ns/100ps
`default_nettype none
module ser_master (
    // serial pins
    output logic           ser_clk,
    output logic           ser_sel_n,
    output logic           ser_in,
    input  wire logic      ser_out_q
);
    // ----
    // frames
    // ----
    initial begin
        ser_clk = 1'b0;
        ser_sel_n = 1'b1;
        ser_in = 1'b0;
    end
    // access bit picks read or clear
    task automatic xfer(input logic [6:0] a, input logic c, input int n,
                        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        w = {d, c, a};
        q = 8'h00;
        // odd offset keeps the link phase apart from ref_clk
        #3.3 ser_sel_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            ser_in = w[i];
            #32 ser_clk = 1'b1;
            if (i > 7)
                q[i-8] = ser_out_q;
            #32 ser_clk = 1'b0;
        end
        #32 ser_sel_n = 1'b1;
        // released line shows no stale value
        ser_in = ~ser_in;
        #120;
    endtask
endmodule // ser_master
`default_nettype wire

// file: test/test_device_bus_fault_status.sv
// self-checking bench for the fault status register bank
// assumes ser_master drives the serial pins; TXEN_CYC shortened to 4
`timescale 1ns/100ps
`default_nettype none
module test_device_bus_fault_status;
    // ----
    // stimulus and checks
    // ----
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [17:0] ev = 18'h0_0000;
    logic [12:0] lv = 13'h0808;
    logic        lin_txi = 1'b1;
    logic        can_txi = 1'b1;
    logic [31:0] seed = 32'h2d21_7f4a;
    logic [7:0]  d;
    logic [7:0]  e;
    int          num_errors = 0;
    int          check_count = 0;
    wire         sck, sel_n, sin, sout, soe, fo, lin_en, can_en;
    wire  [7:0]  dev, bus;
    always #2.5 ref_clk = ~ref_clk;
    device_bus_fault_status #(.TXEN_CYC(4)) u_device_bus_fault_status (
        .ref_clk(ref_clk), .reset_n(reset_n), .soft_reset(ev[16]),
        .restart_entry(ev[17]), .ser_clk(sck), .ser_sel_n(sel_n),
        .ser_in(sin), .ser_out_q(sout), .ser_out_en_q(soe),
        .sleep_wake_evt(ev[0]), .failsafe_wake_evt(ev[1]),
        .thermal_shutdown_level2(ev[2]), .main_supply_low(ev[3]),
        .main_supply_high(ev[4]), .main_overvolt_restart_en(lv[0]),
        .reset_out_stuck_high(ev[5]), .failsafe_input_error(ev[6]),
        .watchdog_fail_count_evt(ev[7]), .wd_trigger_ok(ev[8]),
        .fail_config_one(lv[1]), .fail_outputs_release(ev[9]),
        .fail_output_pins_q(fo), .lin_tsd_evt(ev[10]),
        .lin_tx_stuck_dominant(ev[11]), .lin_line_stuck_dominant(ev[12]),
        .lin_supply_low(lv[2]), .lin_bus_recessive(lv[3]),
        .lin_off_or_wake(lv[4]), .lin_transmit_input(lin_txi),
        .lin_tx_enable(lin_en), .thermal_shutdown_level1(lv[5]),
        .can_tsd_evt(ev[13]), .can_tx_stuck_dominant(ev[14]),
        .can_line_stuck_dominant(ev[15]), .can_supply_below(lv[6]),
        .can_normal_mode(lv[7]), .can_rx_only_mode(lv[8]),
        .can_wake_mode(lv[9]), .wake_pattern_seen(lv[10]),
        .can_bus_recessive(lv[11]), .can_off_or_wake(lv[12]),
        .can_transmit_input(can_txi), .can_tx_enable(can_en),
        .device_info_status_q(dev), .bus_comm_status_one_q(bus));
    ser_master u_ser_master (.ser_clk(sck), .ser_sel_n(sel_n),
        .ser_in(sin), .ser_out_q(sout));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] code(input int k);
        return k[1:0] + 2'h1;
    endfunction
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        check_count++;
        if (s !== x) begin
            num_errors++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, s, x);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(input logic [17:0] m);
        ev = m;
        w(1);
        ev = 18'h0_0000;
        w(2);
    endtask
    task automatic frame(input logic [6:0] a, input logic c, input int n);
        seed = lfsr(seed);
        u_ser_master.xfer(a, c, n, seed[7:0], d);
        w(1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] x);
        frame(a, 1'b0, 16);
        chk(d, x);
        chk({7'h00, soe}, 8'h00);
    endtask
    task automatic close_out;
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        close_out;
    end
    initial begin
        w(3);
        reset_n = 1'b1;
        w(6);
        chk(dev, 8'h00);
        chk(bus, 8'h00);
        rd(7'h43, 8'h00);
        rd(7'h10, 8'h00);
        e = 8'h00;
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            pulse(seed[0] ? 18'h0_0020 : 18'h0_0040);
            e |= seed[0] ? 8'h20 : 8'h10;
            chk(dev, e);
        end
        w(40);
        rd(7'h43, e);
        chk(dev, e);
        frame(7'h43, 1'b1, 16);
        chk(dev, 8'h00);
        pulse(18'h0_0001);
        chk(dev, 8'h80);
        pulse(18'h2_0000);
        chk(dev, 8'h80);
        w(50);
        chk(dev, 8'h80);
        frame(7'h43, 1'b1, 16);
        pulse(18'h0_0010);
        chk(dev, 8'h00);
        for (int i = 0; i < 5; i++) begin
            lv[0] = 1'b1;
            frame(7'h43, 1'b1, 16);
            pulse(i == 4 ? 18'h0_0005 : 18'h0_0010 >> i);
            chk(dev, 8'h40);
        end
        frame(7'h43, 1'b1, 16);
        pulse(18'h0_0080);
        chk(dev, 8'h44);
        chk({7'h00, fo}, 8'h00);
        pulse(18'h0_0080);
        chk(dev, 8'h49);
        chk({7'h00, fo}, 8'h01);
        pulse(18'h0_0080);
        chk(dev, 8'h49);
        frame(7'h43, 1'b1, 16);
        chk(dev, 8'h08);
        pulse(18'h0_0100);
        chk(dev, 8'h00);
        pulse(18'h0_0200);
        lv[1] = 1'b1;
        pulse(18'h0_0080);
        chk({7'h00, fo}, 8'h01);
        chk(dev, 8'h45);
        pulse(18'h0_0320);
        frame(7'h43, 1'b1, 12);
        chk(dev, 8'h63);
        w(50);
        rd(7'h43, 8'h63);
        frame(7'h43, 1'b1, 16);
        chk(dev, 8'h00);
        for (int k = 0; k < 3; k++) begin
            pulse(18'h0_0400 << k);
            pulse(18'h0_2000 << k);
            e = {1'b0, code(k), 2'b00, code(k), 1'b0};
            chk(bus, e);
            pulse(18'h2_0000);
            rd(7'h44, e);
            frame(7'h44, 1'b1, 16);
            chk(bus, 8'h00);
        end
        lin_txi = 1'b0;
        pulse(18'h0_0800);
        w(20);
        chk({7'h00, lin_en}, 8'h00);
        // tx input high for the enable time
        lin_txi = 1'b1;
        w(12);
        chk({7'h00, lin_en}, 8'h01);
        lv[11] = 1'b0;
        pulse(18'h0_8000);
        w(20);
        chk({7'h00, can_en}, 8'h00);
        lv[12] = 1'b1;
        w(12);
        chk({7'h00, can_en}, 8'h01);
        lv[12] = 1'b0;
        lv[11] = 1'b1;
        frame(7'h44, 1'b1, 16);
        lv[6] = 1'b1;
        lv[9] = 1'b1;
        w(10);
        chk(bus, 8'h00);
        lv[10] = 1'b1;
        w(4);
        chk(bus, 8'h01);
        chk({7'h00, can_en}, 8'h00);
        lv[9] = 1'b0;
        lv[7] = 1'b1;
        w(4);
        lv[6] = 1'b0;
        w(12);
        chk({7'h00, can_en}, 8'h01);
        pulse(18'h0_1020);
        pulse(18'h1_0000);
        chk(dev, 8'h00);
        chk(bus, 8'h00);
        close_out;
    end
endmodule // test_device_bus_fault_status
`default_nettype wire
